//--- rtl/acsp_pkg.sv
`default_nettype none
// Shared constants for both ends of the converter serial port.
package acsp_pkg;

    // Frame shape: one 16-clock frame per conversion.
    localparam int unsigned ACSP_FRAME_BITS = 16;
    localparam int unsigned ACSP_CNT_W      = 5;
    localparam int unsigned ACSP_SEL_W      = 3;
    localparam int unsigned ACSP_CTRL_W     = 12;
    localparam int unsigned ACSP_SR_W       = 8;
    localparam int unsigned ACSP_RES_W      = 13;
    localparam int unsigned ACSP_CHAN_W     = 2;

    // Edge numbers within a frame, counted from one.
    localparam logic [ACSP_CNT_W-1:0] ACSP_TRACK_RISE = 5'h0e;
    localparam logic [ACSP_CNT_W-1:0] ACSP_CTRL_LOAD  = 5'h0f;
    localparam logic [ACSP_CNT_W-1:0] ACSP_SR_LOAD    = 5'h0b;
    localparam logic [ACSP_CNT_W-1:0] ACSP_SEL_DONE   = 5'h03;
    localparam logic [ACSP_CNT_W-1:0] ACSP_LAST_FALL  = 5'h10;
    localparam logic [ACSP_CNT_W-1:0] ACSP_CNT_ZERO   = 5'h00;
    localparam logic [ACSP_CNT_W-1:0] ACSP_CNT_ONE    = 5'h01;

    // Select codes; the top bit of the code is the write bit.
    localparam logic [ACSP_SEL_W-1:0] ACSP_SEL_CTRL  = 3'h4;
    localparam logic [ACSP_SEL_W-1:0] ACSP_SEL_SEQ   = 3'h5;
    localparam logic [ACSP_SEL_W-1:0] ACSP_SEL_RANGE = 3'h6;
    localparam int unsigned           ACSP_WR_BIT    = 2;

    // Values after reset.
    localparam logic [ACSP_CTRL_W-1:0] ACSP_CTRL_RST = 12'h000;
    localparam logic [ACSP_SR_W-1:0]   ACSP_SR_RST   = 8'h00;

    // Host timing at the 25 MHz master clock.
    localparam int unsigned ACSP_MCLK_PERIOD_NS = 40;
    localparam int unsigned ACSP_SCLK_HALF_CYC  = 3;
    localparam int unsigned ACSP_HALF_W         = 2;
    localparam int unsigned ACSP_T_QUIET_NS     = 50;
    localparam int unsigned ACSP_QUIET_CYC      =
        (ACSP_T_QUIET_NS + ACSP_MCLK_PERIOD_NS - 1) / ACSP_MCLK_PERIOD_NS;
    localparam int unsigned ACSP_QUIET_W        = 4;

endpackage
`default_nettype wire

//--- rtl/acsp_if.sv
`timescale 1ns/1ps
`default_nettype none
// Serial link between the host and the converter port.
interface acsp_if;
    logic frame_sel_n;
    logic sclk;
    logic sdin;
    logic sdout;
    logic sdout_oe_n;
    logic sdout_line;

    // The data line is pulled high while the converter leaves it undriven.
    assign sdout_line = sdout_oe_n ? 1'b1 : sdout;

    modport dev (
        input  frame_sel_n,
        input  sclk,
        input  sdin,
        output sdout,
        output sdout_oe_n
    );

    modport host (
        output frame_sel_n,
        output sclk,
        output sdin,
        input  sdout_line
    );
endinterface
`default_nettype wire

//--- rtl/acsp_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host end: makes the serial clock from the master clock and runs frames.
module acsp_host
    import acsp_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic        start_in,
    input  wire logic [15:0] cmd_in,
    output logic             busy_out,
    output logic [15:0]      rx_data_out,
    output logic             rx_valid_out,
    acsp_if.host             link
);

    typedef enum logic [1:0] {
        ACSP_H_IDLE,
        ACSP_H_FRAME,
        ACSP_H_END,
        ACSP_H_QUIET
    } acsp_hstate_e;

    localparam logic [ACSP_HALF_W-1:0]  HALF_LAST  = ACSP_HALF_W'(ACSP_SCLK_HALF_CYC - 1);
    localparam logic [ACSP_QUIET_W-1:0] QUIET_LAST = ACSP_QUIET_W'(ACSP_QUIET_CYC - 1);

    acsp_hstate_e            state_q;
    logic [ACSP_HALF_W-1:0]  half_q;
    logic                    sclk_q;
    logic                    frame_sync_n_q;
    logic [15:0]             cmd_q;
    logic [15:0]             rx_q;
    logic [ACSP_CNT_W-1:0]   nfall_q;
    logic [ACSP_QUIET_W-1:0] quiet_q;
    logic                    pend_q;
    logic                    sync1_q;
    logic                    sync2_q;
    logic                    tick;
    logic                    rise_tick;
    logic                    fall_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Free-running divided clock; it keeps running between frames so the
    // converter can reload its output word while the frame select is high.
    assign tick      = (half_q == HALF_LAST);
    assign rise_tick = tick && !sclk_q;
    assign fall_tick = tick && sclk_q;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            half_q <= '0;
            sclk_q <= 1'b1;
        end else if (tick) begin
            half_q <= '0;
            sclk_q <= !sclk_q;
        end else begin
            half_q <= half_q + 1'b1;
        end
    end

    // The returned data comes from the other clock's logic, so synchronise it.
    always_ff @(posedge mclk_in) begin
        sync1_q <= link.sdout_line;
        sync2_q <= sync1_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Requests are latched and launched on a clock edge, so frame starts sit
    // on whole clock periods whatever the request timing is.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pend_q <= 1'b0;
        end else if (start_in && !busy_out) begin
            pend_q <= 1'b1;
        end else if (state_q == ACSP_H_IDLE && rise_tick) begin
            pend_q <= 1'b0;
        end
    end

    // Frame sequencer: sixteen clocks per frame, then the quiet time.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_q        <= ACSP_H_IDLE;
            frame_sync_n_q <= 1'b1;
            cmd_q          <= '0;
            rx_q           <= '0;
            nfall_q        <= '0;
            quiet_q        <= '0;
            rx_valid_out   <= 1'b0;
            rx_data_out    <= '0;
        end else begin
            rx_valid_out <= 1'b0;
            unique case (state_q)
                ACSP_H_IDLE: begin
                    if (pend_q && rise_tick) begin
                        frame_sync_n_q <= 1'b0;
                        state_q        <= ACSP_H_FRAME;
                        nfall_q        <= '0;
                    end
                end
                ACSP_H_FRAME: begin
                    if (fall_tick) begin
                        // Synchronised value is the one before this edge.
                        rx_q    <= {rx_q[14:0], sync2_q};
                        nfall_q <= nfall_q + 1'b1;
                        if (nfall_q == ACSP_LAST_FALL - 1'b1) begin
                            rx_data_out  <= {rx_q[14:0], sync2_q};
                            rx_valid_out <= 1'b1;
                            state_q      <= ACSP_H_END;
                        end
                    end else if (rise_tick && nfall_q != ACSP_CNT_ZERO) begin
                        cmd_q <= {cmd_q[14:0], 1'b0};
                    end
                end
                ACSP_H_END: begin
                    // Raise the select away from the falling edge.
                    if (rise_tick) begin
                        frame_sync_n_q <= 1'b1;
                        quiet_q        <= '0;
                        state_q        <= ACSP_H_QUIET;
                    end
                end
                ACSP_H_QUIET: begin
                    if (quiet_q == QUIET_LAST) begin
                        state_q <= ACSP_H_IDLE;
                    end else begin
                        quiet_q <= quiet_q + 1'b1;
                    end
                end
            endcase
            if (state_q == ACSP_H_IDLE && !pend_q && start_in) begin
                cmd_q <= cmd_in;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (start_in && !busy_out) || pend_q || (state_q != ACSP_H_IDLE);
        end
    end

    assign link.sclk        = sclk_q;
    assign link.frame_sel_n = frame_sync_n_q;
    assign link.sdin        = cmd_q[15];

endmodule
`default_nettype wire

//--- rtl/acsp_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Converter end of the serial port, clocked by the serial clock itself.
module acsp_dev
    import acsp_pkg::*;
(
    input  wire logic                   srst_in,
    input  wire logic [ACSP_RES_W-1:0]  conv_result_in,
    input  wire logic [ACSP_CHAN_W-1:0] conv_chan_in,
    output logic                        hold_out,
    output logic                        abort_out,
    output logic                        frame_done_out,
    output logic [ACSP_CTRL_W-1:0]      ctrl_out,
    output logic [ACSP_SR_W-1:0]        seq_out,
    output logic [ACSP_SR_W-1:0]        range_out,
    acsp_if.dev                         link
);

    logic [ACSP_CNT_W-1:0]       fall_cnt_q;
    logic [ACSP_CNT_W-1:0]       rise_cnt_q;
    logic [ACSP_FRAME_BITS-1:0]  rx_q;
    logic [ACSP_FRAME_BITS-1:0]  tx_q;
    logic [ACSP_SEL_W-1:0]       sel_q;
    logic                        hiz_q;
    logic                        frame_on;
    logic                        ctrl_hit;
    logic                        sr_hit;
    logic [ACSP_SEL_W-1:0]       sel_now;
    logic                        srst_meta_q;
    logic                        srst_q;

    ////////////////////////////////////////////////////////////////////////////
    // Frame state. The frame select is driven by the host on the same link
    // clock, so it is used directly; a high select ends any frame at once.

    assign frame_on = !link.frame_sel_n;

    // The reset request comes from logic on the master clock, which has no
    // fixed phase to the link clock. It passes two flops on the link clock
    // before anything here reads it, so no register can see a metastable
    // level. The cost is that reset lands two link clocks late, and only
    // while the host keeps the link clock running; a host that stops its
    // clock during reset leaves this end in its previous state.
    always_ff @(negedge link.sclk) begin
        srst_meta_q <= srst_in;
        srst_q      <= srst_meta_q;
    end

    // Falling-edge counter: value k means k falling edges seen in the frame.
    // It stops at sixteen so a select held low afterwards does nothing.
    always_ff @(negedge link.sclk) begin
        if (srst_q || !frame_on) begin
            fall_cnt_q <= ACSP_CNT_ZERO;
        end else if (fall_cnt_q != ACSP_LAST_FALL) begin
            fall_cnt_q <= fall_cnt_q + 1'b1;
        end
    end

    // Rising-edge counter, used only to time the return to track.
    always_ff @(posedge link.sclk) begin
        if (srst_q || !frame_on) begin
            rise_cnt_q <= ACSP_CNT_ZERO;
        end else if (rise_cnt_q != ACSP_LAST_FALL) begin
            rise_cnt_q <= rise_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Track-and-hold. Hold starts with the frame and ends on the fourteenth
    // rising edge. Because this flop only moves on clock edges, hold is seen
    // at the first rising edge at or after the select fall; the host lowers the select on a rising edge, so no delay.
    always_ff @(posedge link.sclk) begin
        if (srst_q || !frame_on) begin
            hold_out <= 1'b0;
        end else begin
            // The rising edge on which the select falls is counted as well,
            // so the count reaches fourteen on the thirteenth rising edge
            // after the select fell; hold drops on the fourteenth edge.
            hold_out <= (rise_cnt_q < ACSP_TRACK_RISE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input shifting: one bit per falling edge, most significant first.
    always_ff @(negedge link.sclk) begin
        if (srst_q) begin
            rx_q <= '0;
        end else if (frame_on && fall_cnt_q != ACSP_LAST_FALL) begin
            rx_q <= {rx_q[ACSP_FRAME_BITS-2:0], link.sdin};
        end
    end

    // The select code is complete on the third falling edge; it is held for
    // the rest of the frame so later input bits cannot redirect a load.
    assign sel_now = {rx_q[1:0], link.sdin};

    always_ff @(negedge link.sclk) begin
        if (srst_q || !frame_on) begin
            sel_q <= '0;
        end else if (fall_cnt_q == ACSP_SEL_DONE - 1'b1) begin
            sel_q <= sel_now;
        end
    end

    // Write bit is the top bit of the code; without it nothing is stored.
    assign ctrl_hit = sel_q[ACSP_WR_BIT] && (sel_q == ACSP_SEL_CTRL);
    assign sr_hit   = sel_q[ACSP_WR_BIT] &&
                      ((sel_q == ACSP_SEL_SEQ) || (sel_q == ACSP_SEL_RANGE));

    ////////////////////////////////////////////////////////////////////////////
    // Control register: the twelve bits after the code, taken on edge fifteen.
    // An abort before that edge leaves it untouched, one after it keeps the
    // new value; the sixteenth input bit is never used.
    always_ff @(negedge link.sclk) begin
        if (srst_q) begin
            ctrl_out <= ACSP_CTRL_RST;
        end else if (frame_on && ctrl_hit && fall_cnt_q == ACSP_CTRL_LOAD - 1'b1) begin
            ctrl_out <= {rx_q[ACSP_CTRL_W-2:0], link.sdin};
        end
    end

    // Sequence register: eight bits after the code, taken on edge eleven.
    // The remaining input bits of the frame fall after this edge and are
    // dropped, so a host may pad them with anything.
    always_ff @(negedge link.sclk) begin
        if (srst_q) begin
            seq_out <= ACSP_SR_RST;
        end else if (frame_on && sr_hit && sel_q == ACSP_SEL_SEQ &&
                     fall_cnt_q == ACSP_SR_LOAD - 1'b1) begin
            seq_out <= {rx_q[ACSP_SR_W-2:0], link.sdin};
        end
    end

    // Range register: same timing as the sequence register.
    // Sharing the load edge keeps one compare for both registers; the code
    // held in the select flop decides which of the two takes the bits.
    always_ff @(negedge link.sclk) begin
        if (srst_q) begin
            range_out <= ACSP_SR_RST;
        end else if (frame_on && sr_hit && sel_q == ACSP_SEL_RANGE &&
                     fall_cnt_q == ACSP_SR_LOAD - 1'b1) begin
            range_out <= {rx_q[ACSP_SR_W-2:0], link.sdin};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output word. While the select is high the word is reloaded on every
    // falling edge, so the leading zero already stands on the line when the
    // select falls. This relies on the clock running between frames.
    always_ff @(negedge link.sclk) begin
        if (srst_q) begin
            tx_q <= '0;
        end else if (!frame_on) begin
            tx_q <= {1'b0, conv_chan_in, conv_result_in};
        end else begin
            tx_q <= {tx_q[ACSP_FRAME_BITS-2:0], 1'b0};
        end
    end

    // Release flag for the data line, set on the sixteenth falling edge.
    always_ff @(negedge link.sclk) begin
        if (srst_q || !frame_on) begin
            hiz_q <= 1'b0;
        end else if (fall_cnt_q == ACSP_LAST_FALL - 1'b1) begin
            hiz_q <= 1'b1;
        end
    end

    // The enable must follow the select without waiting for a clock edge,
    // so it is the one link output that is not taken straight from a flop.
    assign link.sdout_oe_n = link.frame_sel_n || hiz_q;
    assign link.sdout      = tx_q[ACSP_FRAME_BITS-1];

    ////////////////////////////////////////////////////////////////////////////
    // Status pulses for the converter core.
    // Both pulses last one link clock period; a core on another clock must
    // stretch or synchronise them before use, since a single sample of the
    // master clock could miss a pulse if the link clock ran much faster.
    always_ff @(negedge link.sclk) begin
        if (srst_q) begin
            abort_out      <= 1'b0;
            frame_done_out <= 1'b0;
        end else begin
            // A select rise with a partial count is an aborted conversion.
            abort_out      <= !frame_on && fall_cnt_q != ACSP_CNT_ZERO &&
                              fall_cnt_q != ACSP_LAST_FALL;
            frame_done_out <= frame_on && fall_cnt_q == ACSP_LAST_FALL - 1'b1;
        end
    end

endmodule
`default_nettype wire

//--- test/acsp_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the host-to-converter link, sampled by the master clock.
module acsp_link_assertions (
    input  wire logic mclk_in,
    input  wire logic srst_in,
    input  wire logic frame_sel_n,
    input  wire logic sclk,
    input  wire logic sdin,
    input  wire logic sdout,
    input  wire logic sdout_oe_n,
    input  wire logic sdout_line
);
    logic       sclk_q;
    logic [4:0] falls_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Previous serial clock level, so falls can be counted in the master domain.
    always_ff @(posedge mclk_in) begin
        sclk_q <= sclk;
    end

    // Falling serial clock edges within the frame; cleared while select is high.
    always_ff @(posedge mclk_in) begin
        if (srst_in || frame_sel_n) begin
            falls_q <= 5'h00;
        end else if (sclk_q && !sclk) begin
            falls_q <= falls_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The device reset is the longer one, so it gates every check.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    chk_zero_lead: assert property (
        $fell(frame_sel_n) |-> !sdout_oe_n && !sdout_line)
        else $error("leading zero not driven at select fall");
    chk_idle_released: assert property (
        frame_sel_n |-> sdout_oe_n && sdout_line)
        else $error("data line driven while select is high");
    chk_frame_driven: assert property (
        !frame_sel_n && !$fell(sclk) && falls_q <= 5'h0f |-> !sdout_oe_n)
        else $error("data line released inside the frame");
    chk_release_sixteen: assert property (
        (falls_q == 5'h10) || ($fell(sclk) && falls_q == 5'h0f) |-> sdout_oe_n)
        else $error("data line still driven after falling edge sixteen");
    chk_sixteen_clocks: assert property (
        $rose(frame_sel_n) |-> falls_q == 5'h10)
        else $error("frame did not hold sixteen falling edges");
    chk_shift_on_fall: assert property (
        !frame_sel_n && !$past(frame_sel_n) && $changed(sdout) |-> $fell(sclk))
        else $error("output bit changed away from a falling edge");
    chk_select_on_rise: assert property (
        $fell(frame_sel_n) |-> $rose(sclk))
        else $error("select lowered off a rising clock phase");
    chk_quiet_gap: assert property (
        $rose(frame_sel_n) |=> frame_sel_n [*2])
        else $error("quiet time between frames too short");
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Both link ends face each other; a second converter is driven by hand to cut frames short.
module testbench;
    import acsp_pkg::*;
    logic        mclk_in  = 1'b0;
    logic        srst     = 1'b1;
    logic        dev_srst = 1'b1;
    logic        start    = 1'b0;
    logic [15:0] cmd      = 16'h0000;
    logic [12:0] res      = 13'h0000;
    logic [1:0]  chan     = 2'h0;
    logic [31:0] rng      = 32'h0000_3496;
    logic        sel_at_fall = 1'b1;
    logic        busy, rx_valid, hold, abort1, done1, hold2, abort2, done2;
    logic [15:0] rx_data;
    logic [11:0] ctrl, ctrl2;
    logic [7:0]  seq, range_v, seq2, range2;
    int          fails = 0, checked = 0, rises = 0, dones = 0, aborts = 0, stray = 0;
    int          m[6] = '{0, 0, 0, 0, 0, 0};

    acsp_if lk();
    acsp_if lk2();
    acsp_host i_acsp_host (.mclk_in(mclk_in), .srst_in(srst), .start_in(start), .cmd_in(cmd),
        .busy_out(busy), .rx_data_out(rx_data), .rx_valid_out(rx_valid), .link(lk.host));
    acsp_dev i_acsp_dev (.srst_in(dev_srst), .conv_result_in(res), .conv_chan_in(chan),
        .hold_out(hold), .abort_out(abort1), .frame_done_out(done1), .ctrl_out(ctrl),
        .seq_out(seq), .range_out(range_v), .link(lk.dev));
    acsp_dev i_acsp_dev_cut (.srst_in(dev_srst), .conv_result_in(res), .conv_chan_in(chan),
        .hold_out(hold2), .abort_out(abort2), .frame_done_out(done2), .ctrl_out(ctrl2),
        .seq_out(seq2), .range_out(range2), .link(lk2.dev));
    acsp_link_assertions i_acsp_link_assertions (.mclk_in(mclk_in), .srst_in(dev_srst),
        .frame_sel_n(lk.frame_sel_n), .sclk(lk.sclk), .sdin(lk.sdin), .sdout(lk.sdout),
        .sdout_oe_n(lk.sdout_oe_n), .sdout_line(lk.sdout_line));

    ////////////////////////////////////////////////////////////////////////////////
    // Master clock; the hand-driven link runs free because the converter preloads between frames.
    always #20 mclk_in = ~mclk_in;
    initial begin
        lk2.sclk = 1'b1;
        #3.3;
        forever #7.5 lk2.sclk = ~lk2.sclk;
    end

    // Rising edges are counted only once select was low at the previous fall.
    always @(negedge lk.sclk) begin
        sel_at_fall = lk.frame_sel_n;
        if (sel_at_fall) rises = 0;
    end
    always @(posedge lk.sclk) if (!sel_at_fall) begin
        rises++;
        #1 chk(hold, rises < 14);
    end
    always @(posedge done1) dones++;
    always @(posedge abort2) aborts++;
    // Full frames never abort and cut frames never finish.
    always @(posedge abort1 or posedge done2) stray++;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("mismatches %0d comparisons %0d", fails, checked);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Register model: a write lands only if the frame reached its load edge.
    task automatic model(input logic [15:0] c, input int falls, input int b);
        if (c[15:13] == ACSP_SEL_CTRL && falls >= 15) m[b] = c[12:1];
        if (c[15:13] == ACSP_SEL_SEQ && falls >= 11) m[b+1] = c[12:5];
        if (c[15:13] == ACSP_SEL_RANGE && falls >= 11) m[b+2] = c[12:5];
    endtask

    task automatic chk_regs();
        chk(ctrl, m[0]);
        chk(seq, m[1]);
        chk(range_v, m[2]);
        chk(ctrl2, m[3]);
        chk(seq2, m[4]);
        chk(range2, m[5]);
    endtask

    // A bounded wait on a level; running out ends the run as a failure.
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v) begin
            if (n == 500) begin
                fails++;
                final_report();
            end
            @(posedge mclk_in);
            #1;
            n++;
        end
    endtask

    task automatic host_frame(input logic [15:0] c);
        @(posedge mclk_in);
        #1 start = 1'b1;
        cmd = c;
        @(posedge mclk_in);
        #1 start = 1'b0;
        wait_for(rx_valid, 1'b1);
        chk(rx_data, {1'b0, chan, res});
        model(c, 16, 0);
        wait_for(busy, 1'b0);
        chk_regs();
    endtask

    // Select rises after n falling edges, before the sixteenth.
    task automatic cut_frame(input logic [15:0] c, input int n);
        @(posedge lk2.sclk);
        #1 lk2.frame_sel_n = 1'b0;
        lk2.sdin = c[15];
        #1 chk(lk2.sdout_line, 1'b0);
        for (int k = 1; k < n; k++) begin
            @(posedge lk2.sclk);
            #1 lk2.sdin = c[15-k];
        end
        @(posedge lk2.sclk);
        #1 lk2.frame_sel_n = 1'b1;
        repeat (2) @(posedge lk2.sclk);
        #1 chk(lk2.sdout_line, 1'b1);
        model(c, n, 3);
        chk_regs();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        int          cut_code[7] = '{4, 4, 4, 5, 5, 6, 6};
        int          cut_falls[7] = '{1, 14, 15, 10, 11, 10, 11};
        lk2.frame_sel_n = 1'b1;
        lk2.sdin = 1'b0;
        repeat (20) @(posedge mclk_in);
        #1 srst = 1'b0;
        repeat (20) @(posedge mclk_in);
        #1 dev_srst = 1'b0;
        repeat (12) @(posedge mclk_in);
        chk_regs();
        // Every select code, three times, with random payload and conversion data.
        for (int i = 0; i < 24; i++) begin
            @(posedge mclk_in);
            #1 r = xs();
            res = r[12:0];
            chan = r[14:13];
            repeat (8) @(posedge mclk_in);
            host_frame({3'(i), r[28:16]});
        end
        for (int i = 0; i < 7; i++) begin
            r = xs();
            cut_frame({3'(cut_code[i]), r[12:0]}, cut_falls[i]);
        end
        repeat (4) @(posedge mclk_in);
        chk(dones, 24);
        chk(aborts, 7);
        chk(stray, 0);
        final_report();
    end
endmodule
`default_nettype wire
